// *** hdl/i2c_status_flags.sv ***
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`include "i2c_flags_params.svh"

module i2c_status_flags
   import i2c_flags_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire engine_ev_s  engine_i,
   output logic             error_halt_flag_o,
   output logic             normal_stop_flag_o,
   output logic             continuous_xfer_request_flag_o,
   output logic             main_interrupt_flag_o,
   output logic             interface_enable_bit_o
);

   // ============================================================
   // Clear by write 0 only when the flag was read as 1 beforehand.
   function automatic logic sw_clear(input logic armed,
                                     input logic wr,
                                     input logic [31:0] data,
                                     input int unsigned pos);
      sw_clear = armed & wr & ~data[pos];
   endfunction

   // ============================================================
   // Register state.
   ahb_req_s   req_ff;
   logic       err_halt_ff;
   logic       norm_stop_ff;
   logic       cont_xfer_ff;
   logic       main_irq_ff;
   logic       if_enable_ff;
   logic       master_ff;
   logic       sync_fmt_ff;
   logic       arm_err_ff;
   logic       arm_stop_ff;
   logic       arm_cont_ff;
   logic       arm_main_ff;
   logic [31:0] rdata_ff;

   // ============================================================
   // Decoded bus activity.
   logic        addr_take;
   logic        wr_status;
   logic        wr_control;
   logic        rd_status;
   logic        rd_control;
   logic [31:0] status_word;
   logic [31:0] control_word;

   // ============================================================
   // Flag events.
   logic slave_mode;
   logic stop_err_set;
   logic stop_norm_set;
   logic cont_set;
   logic main_set;
   logic main_clr;
   logic err_clr;
   logic stop_clr;
   logic cont_clr;

   // The slave is always ready, so every transfer has one wait-free
   // data phase and the answer is always OKAY.
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_ff;

   // Only single word transfers are issued, so hsize is not decoded.
   assign addr_take = hsel_i & hready_i & (htrans_i == `HTRANS_NONSEQ);
   assign rd_status = addr_take & ~hwrite_i
                    & (haddr_i[7:0] == `OFS_STATUS);
   assign rd_control = addr_take & ~hwrite_i
                     & (haddr_i[7:0] == `OFS_CONTROL);
   assign wr_status = req_ff.valid & req_ff.write
                    & (req_ff.addr == `OFS_STATUS);
   assign wr_control = req_ff.valid & req_ff.write
                     & (req_ff.addr == `OFS_CONTROL);

   // Assemble the readable words; bits not held read as zero.
   always_comb
   begin
      status_word = `WORD_ZERO;
      status_word[`BIT_ERR_HALT]  = err_halt_ff;
      status_word[`BIT_NORM_STOP] = norm_stop_ff;
      status_word[`BIT_CONT_XFER] = cont_xfer_ff;
      control_word = `WORD_ZERO;
      control_word[`BIT_IF_ENABLE] = if_enable_ff;
      control_word[`BIT_MASTER]    = master_ff;
      control_word[`BIT_SYNC_FMT]  = sync_fmt_ff;
      control_word[`BIT_MAIN_IRQ]  = main_irq_ff;
   end

   // ============================================================
   // Address phase capture for the following data phase.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         req_ff <= '0;
      end
      else if (hready_i)
      begin
         req_ff.valid <= addr_take;
         req_ff.write <= hwrite_i;
         req_ff.addr  <= haddr_i[7:0];
      end
   end

   // Read data is latched at the address edge so it stands in the
   // data phase; unmapped addresses read as zero.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         rdata_ff <= `WORD_ZERO;
      end
      else if (rd_status)
      begin
         rdata_ff <= status_word;
      end
      else if (rd_control)
      begin
         rdata_ff <= control_word;
      end
      else if (addr_take)
      begin
         rdata_ff <= `WORD_ZERO;
      end
   end

   // ============================================================
   // Mode decode and event qualification.
   assign slave_mode = ~master_ff & ~sync_fmt_ff;
   // The stop flags are only set in bus-format slave mode.
   assign stop_err_set  = slave_mode & engine_i.stop_detect
                        & engine_i.in_frame;
   assign stop_norm_set = slave_mode & engine_i.stop_detect
                        & ~engine_i.in_frame;
   // Frame completion raises the streaming request; in slave mode only with a second address match.
   assign cont_set = (engine_i.tx_empty_set | engine_i.rx_full_set)
                   & (slave_mode ? engine_i.second_addr
                                 : 1'b1);
   assign main_set = cont_set | engine_i.other_irq;

   // A main flag clear only counts when no set collides with it.
   assign main_clr = sw_clear(arm_main_ff, wr_control, hwdata_i,
                              `BIT_MAIN_IRQ) & ~main_set;
   assign err_clr  = sw_clear(arm_err_ff, wr_status, hwdata_i,
                              `BIT_ERR_HALT) | main_clr;
   assign stop_clr = sw_clear(arm_stop_ff, wr_status, hwdata_i,
                              `BIT_NORM_STOP) | main_clr;
   assign cont_clr = sw_clear(arm_cont_ff, wr_status, hwdata_i,
                              `BIT_CONT_XFER)
                   | (main_clr & if_enable_ff);

   // ============================================================
   // Error-halt flag; a new set wins over a clear in the same cycle,
   // and a normal-stop set knocks it down to keep the pair exclusive.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         err_halt_ff <= `FLAG_RST;
      end
      else if (stop_err_set)
      begin
         err_halt_ff <= 1'b1;
      end
      else if (stop_norm_set | err_clr)
      begin
         err_halt_ff <= 1'b0;
      end
   end

   // Normal-stop flag, mirror image of the error-halt flag.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         norm_stop_ff <= `FLAG_RST;
      end
      else if (stop_norm_set)
      begin
         norm_stop_ff <= 1'b1;
      end
      else if (stop_err_set | stop_clr)
      begin
         norm_stop_ff <= 1'b0;
      end
   end

   // Continuous-transfer request flag.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         cont_xfer_ff <= `FLAG_RST;
      end
      else if (cont_set)
      begin
         cont_xfer_ff <= 1'b1;
      end
      else if (cont_clr)
      begin
         cont_xfer_ff <= 1'b0;
      end
   end

   // Main interrupt flag; set in the same edge as the request flag.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         main_irq_ff <= `FLAG_RST;
      end
      else if (main_set)
      begin
         main_irq_ff <= 1'b1;
      end
      else if (main_clr)
      begin
         main_irq_ff <= 1'b0;
      end
   end

   // ============================================================
   // Read-of-one arming. A read of the word arms each bit seen at 1;
   // any write to that word disarms, so a second write 0 needs a
   // fresh read. A bit that drops to 0 on its own also disarms.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         arm_err_ff  <= 1'b0;
         arm_stop_ff <= 1'b0;
         arm_cont_ff <= 1'b0;
      end
      else if (rd_status)
      begin
         arm_err_ff  <= err_halt_ff;
         arm_stop_ff <= norm_stop_ff;
         arm_cont_ff <= cont_xfer_ff;
      end
      else if (wr_status)
      begin
         arm_err_ff  <= 1'b0;
         arm_stop_ff <= 1'b0;
         arm_cont_ff <= 1'b0;
      end
      else
      begin
         arm_err_ff  <= arm_err_ff & err_halt_ff;
         arm_stop_ff <= arm_stop_ff & norm_stop_ff;
         arm_cont_ff <= arm_cont_ff & cont_xfer_ff;
      end
   end

   // Arming for the main interrupt flag in the control word.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         arm_main_ff <= 1'b0;
      end
      else if (rd_control)
      begin
         arm_main_ff <= main_irq_ff;
      end
      else if (wr_control)
      begin
         arm_main_ff <= 1'b0;
      end
      else
      begin
         arm_main_ff <= arm_main_ff & main_irq_ff;
      end
   end

   // ============================================================
   // Plain control bits, written directly by software.
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         {if_enable_ff, master_ff, sync_fmt_ff} <= `CTRL_RST;
      end
      else if (wr_control)
      begin
         if_enable_ff <= hwdata_i[`BIT_IF_ENABLE];
         master_ff    <= hwdata_i[`BIT_MASTER];
         sync_fmt_ff  <= hwdata_i[`BIT_SYNC_FMT];
      end
   end

   // ============================================================
   // Flag outputs straight from their flip-flops.
   assign error_halt_flag_o              = err_halt_ff;
   assign normal_stop_flag_o             = norm_stop_ff;
   assign continuous_xfer_request_flag_o = cont_xfer_ff;
   assign main_interrupt_flag_o          = main_irq_ff;
   assign interface_enable_bit_o         = if_enable_ff;

endmodule

// *** hdl/i2c_flags_params.svh ***
`ifndef I2C_FLAGS_PARAMS_SVH
`define I2C_FLAGS_PARAMS_SVH

// ============================================================
// Register map
`define OFS_STATUS      8'h00
`define OFS_CONTROL     8'h04
`define ADDR_LSB_W      8

// ============================================================
// Status register bit positions
`define BIT_ERR_HALT    7
`define BIT_NORM_STOP   6
`define BIT_CONT_XFER   5

// ============================================================
// Control register bit positions
`define BIT_IF_ENABLE   7
`define BIT_MASTER      6
`define BIT_SYNC_FMT    5
`define BIT_MAIN_IRQ    0

// ============================================================
// Reset values and constants
`define FLAG_RST        1'b0
`define CTRL_RST        3'h0
`define WORD_ZERO       32'h0000_0000
`define HTRANS_NONSEQ   2'h2

`endif

// *** hdl/i2c_flags_pkg.sv ***
package i2c_flags_pkg;

   // ============================================================
   // Address phase of an AHB-Lite transfer, held for its data phase.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } ahb_req_s;

   // ============================================================
   // Events and levels from the bus engine.
   typedef struct packed {
      logic stop_detect;    // One-cycle pulse on a stop condition.
      logic in_frame;       // High while a frame is being moved.
      logic tx_empty_set;   // Pulse: transmit-empty flag became 1.
      logic rx_full_set;    // Pulse: receive-full flag became 1.
      logic second_addr;    // Second-address-match flag level.
      logic other_irq;      // Pulse: any other main interrupt source.
   } engine_ev_s;

endpackage

// *** bench/i2c_engine_model.sv ***
module i2c_engine_model
   import i2c_flags_pkg::*;
(
   input  wire logic clk_sys_i,
   output engine_ev_s engine_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // ============================================================
   // Event source
   // Pulses last one cycle; the frame and second-address levels stay
   // up after it, as the real engine holds them until its next event.
   initial engine_o = '0;

   task automatic send(input engine_ev_s e, input int gap);
      repeat (gap) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      engine_o <= e;
      @(posedge clk_sys_i);
      engine_o <= e & 6'h12;
   endtask
endmodule

// *** bench/i2c_status_flags_asserts.sv ***
module i2c_status_flags_asserts
   import i2c_flags_pkg::*;
(
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   input wire engine_ev_s engine_i,
   input wire logic       error_halt_flag_o,
   input wire logic       normal_stop_flag_o,
   input wire logic       continuous_xfer_request_flag_o,
   input wire logic       main_interrupt_flag_o,
   input wire logic       interface_enable_bit_o
);
   // ============================================================
   // Aliases
   // Short names keep every property within two lines.
   wire eh = error_halt_flag_o;
   wire ns = normal_stop_flag_o;
   wire cx = continuous_xfer_request_flag_o;
   wire mi = main_interrupt_flag_o;
   wire ie = interface_enable_bit_o;
   wire sp = engine_i.stop_detect;
   wire fr = engine_i.in_frame;
   wire dx = engine_i.tx_empty_set | engine_i.rx_full_set;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // ============================================================
   // Properties
   // A flag may only rise one edge after its cause was sampled.
   a_err_cause: assert property ($rose(eh) |-> $past(sp && fr))
      else $error("error halt rose without a stop in frame");
   a_norm_cause: assert property ($rose(ns) |-> $past(sp && !fr))
      else $error("normal stop rose without a stop");
   a_cx_cause: assert property ($rose(cx) |-> $past(dx))
      else $error("stream flag rose without a frame end");
   a_cx_main: assert property ($rose(cx) |-> mi)
      else $error("main flag not set with stream flag");
   a_stop_excl: assert property (!(eh && ns))
      else $error("both stop flags set");
   // A stop landing on the clearing edge wins, so it is left out here.
   a_main_side: assert property (
      $fell(mi) && !$past(sp) |-> !eh && !ns)
      else $error("stop flag survived main flag clear");
   a_main_cx: assert property ($fell(mi) && $past(ie) |-> !cx)
      else $error("stream flag survived main flag clear");
   a_reset_zero: assert property ($rose(rst_n_i) |-> !(eh | ns | cx))
      else $error("flags not zero after reset");

   c_err: cover property ($rose(eh));
   c_norm: cover property ($rose(ns));
   c_cx_clr: cover property ($fell(mi) && $past(ie));
endmodule

bind i2c_status_flags i2c_status_flags_asserts u_chk (
   .clk_sys_i,
   .rst_n_i,
   .engine_i,
   .error_halt_flag_o,
   .normal_stop_flag_o,
   .continuous_xfer_request_flag_o,
   .main_interrupt_flag_o,
   .interface_enable_bit_o
);

// *** bench/i2c_status_flags_tb.sv ***
module i2c_status_flags_tb
   import i2c_flags_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic [31:0] hrdata_o, rd;
   logic        hreadyout_o, hresp_o, eh, ns, cx, mi, ie;
   logic [7:0]  ctl;
   logic [1:0]  tr;
   engine_ev_s  ev;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          m, ien, inf;

   i2c_status_flags DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .engine_i(ev),
      .error_halt_flag_o(eh), .normal_stop_flag_o(ns),
      .continuous_xfer_request_flag_o(cx), .main_interrupt_flag_o(mi),
      .interface_enable_bit_o(ie));
   i2c_engine_model MDL (.clk_sys_i(clk_sys_i), .engine_o(ev));

   // ============================================================
   // Clock and watchdog
   initial forever #20 clk_sys_i = ~clk_sys_i;
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      summarize();
   end

   // ============================================================
   // Bus master
   // Each phase is held until hready is seen high at an edge.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge clk_sys_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= w;
      haddr_i <= {24'h0, a};
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, hresp_o}, 32'h0);
   endtask

   // Stop flags live only in slave modes 0 and 1; stream flag is
   // raised in every mode but plain slave without second address.
   function automatic logic [31:0] stat(input int m, input int f);
      return {24'h0, m < 2 && f == 1, m < 2 && f == 0, m != 0, 5'h0};
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ============================================================
   // Tests
   initial
   begin
      void'($urandom(32'hFAD5333C));
      repeat (8) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h0);
      xfer(1'b1, 8'h00, 32'hFFFF_FFFF);
      xfer(1'b1, 8'h08, 32'hFFFF_FFFF);
      rdchk(8'h00, 32'h0);
      rdchk(8'h08, 32'h0);
      $display("test reset done");
      // A write of zero before any read must leave the flag alone.
      xfer(1'b1, 8'h04, 32'h80);
      MDL.send(6'h30, 0);
      xfer(1'b1, 8'h00, 32'h0);
      rdchk(8'h00, stat(0, 1));
      MDL.send(6'h20, 2);
      rdchk(8'h00, stat(0, 0));
      xfer(1'b1, 8'h00, 32'h0);
      rdchk(8'h00, 32'h0);
      $display("test stop done");
      // Random modes: 0 slave, 1 slave with second address, 2 master,
      // 3 synchronous; every iteration also clears through the main flag.
      for (int i = 0; i < 24; i++)
      begin
         m = $urandom % 4;
         ien = $urandom % 2;
         inf = $urandom % 2;
         tr = 2'($urandom % 3 + 1);
         ctl = {ien[0], m == 2, m == 3, 5'h0};
         xfer(1'b1, 8'h04, {24'h0, ctl});
         MDL.send({1'b1, inf[0], tr, m == 1, 1'b1}, $urandom % 3);
         rdchk(8'h00, stat(m, inf));
         chk({29'h0, eh, ns, cx}, stat(m, inf) >> 5);
         chk({31'h0, ie}, 32'(ien));
         rdchk(8'h04, {24'h0, ctl | 8'h01});
         xfer(1'b1, 8'h04, {24'h0, ctl});
         rdchk(8'h00, stat(m, inf) & (ien ? 0 : 32'h20));
         chk({31'h0, mi}, 32'h0);
         xfer(1'b1, 8'h00, 32'h0);
         rdchk(8'h00, 32'h0);
      end
      $display("test modes done");
      summarize();
   end
endmodule
